/* File: hw/mmu_pkg.sv */
// constants and types for the level one translation block
package mmu_pkg;
    // ==========================================================
    // buffer geometry
    localparam int unsigned ENTRIES   = 64;
    localparam int unsigned IDX_W     = 6;
    localparam logic [5:0]  VICTIM_MAX = 6'h3F;
    localparam int unsigned SIDE_DATA  = 0;
    localparam int unsigned SIDE_INSTR = 1;

    // ==========================================================
    // coprocessor register numbers
    localparam logic [3:0] REG_CONTROL      = 4'h1;
    localparam logic [3:0] REG_TABLE_BASE   = 4'h2;
    localparam logic [3:0] REG_DOMAIN       = 4'h3;
    localparam logic [3:0] REG_FAULT_STATUS = 4'h5;
    localparam logic [3:0] REG_FAULT_ADDR   = 4'h6;
    localparam logic [3:0] REG_BUF_OPS      = 4'h8;
    localparam logic [3:0] REG_LOCKDOWN     = 4'hA;
    localparam logic [3:0] REG_RELOC_ID     = 4'hD;
    localparam logic [2:0] OPC2_DATA        = 3'h0;
    localparam logic [2:0] OPC2_INSTR       = 3'h1;

    // ==========================================================
    // maintenance action selection
    localparam logic [2:0] OPS_INV_ALL   = 3'h0;
    localparam logic [2:0] OPS_INV_ENTRY = 3'h1;
    localparam logic [3:0] CRM_INSTR     = 4'h5;
    localparam logic [3:0] CRM_DATA      = 4'h6;
    localparam logic [3:0] CRM_BOTH      = 4'h7;

    // ==========================================================
    // field positions
    localparam int unsigned CTRL_M_BIT = 0;
    localparam int unsigned CTRL_A_BIT = 1;
    localparam int unsigned CTRL_S_BIT = 8;
    localparam int unsigned CTRL_R_BIT = 9;
    localparam int unsigned TB_LSB     = 14;
    localparam int unsigned L1_IDX_LSB = 20;
    localparam int unsigned LK_BASE_MSB = 31;
    localparam int unsigned LK_BASE_LSB = 26;
    localparam int unsigned LK_VIC_MSB  = 25;
    localparam int unsigned LK_VIC_LSB  = 20;
    localparam int unsigned LK_P_BIT    = 0;
    localparam int unsigned FS_DOM_MSB  = 7;
    localparam int unsigned FS_DOM_LSB  = 4;
    localparam int unsigned DESC_DOM_MSB = 8;
    localparam int unsigned DESC_DOM_LSB = 5;
    localparam int unsigned RELOC_LSB   = 25;
    localparam logic [3:0]  FAULT_SECTION_XLAT = 4'h5;

    // ==========================================================
    // reset values
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
    localparam logic [6:0]  RELOC_RST   = 7'h00;

    typedef enum logic [1:0] {
        DESC_INVALID = 2'b00,
        DESC_COARSE  = 2'b01,
        DESC_SECTION = 2'b10,
        DESC_FINE    = 2'b11
    } desc_type_e;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_LOOKUP = 3'b001,
        ST_FETCH  = 3'b010,
        ST_FILL   = 3'b011,
        ST_RESP   = 3'b100
    } walk_state_e;
endpackage

/* File: hw/mmu_level_one.sv */
// memory management control registers and level one walk
//
// Operation
// - control: translate enable, alignment, protection bits
// - table base holds bits 31..14 only
// - table base low fourteen bits read zero
// - domain register: sixteen two-bit fields
// - fault status records domain and type
// - fault address captures data abort address
// - hardware updates fault status on abort, fault address on data abort only
// - maintenance register acts on write, unreadable
// - invalidate all unpreserved, or one entry
// - separate lockdown per buffer, opcode selects
// - other registers readable and writable
// - relocated core addresses translated via buffer
// - buffer miss starts a table walk
// - walk starts with level one fetch
// - level one table: 4096 one-megabyte entries
// - fetch address: base bits plus address bits
// - fetched word is the level one descriptor
// - low addresses relocated by identifier times 32MB
// - lockdown fields; victim wraps 63 to base
// - descriptor type decode; invalid faults
`timescale 1ns/1ps

module mmu_level_one (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    // coprocessor transfers
    input  wire logic        i_cp_valid,
    input  wire logic        i_cp_write,
    input  wire logic [3:0]  i_cp_reg,
    input  wire logic [3:0]  i_cp_crm,
    input  wire logic [2:0]  i_cp_opc2,
    input  wire logic [31:0] i_cp_wdata,
    output logic             o_cp_rvalid,
    output logic [31:0]      o_cp_rdata,
    // core access requests
    input  wire logic        i_req_valid,
    input  wire logic        i_req_instr,
    input  wire logic [31:0] i_req_addr,
    output logic             o_req_ready,
    output logic             o_resp_valid,
    output logic [31:0]      o_resp_paddr,
    output logic             o_resp_abort,
    output logic             o_resp_level2,
    output logic [31:0]      o_resp_desc,
    // physical memory descriptor fetch
    output logic             o_mem_req,
    output logic [29:0]      o_mem_addr,
    input  wire logic        i_mem_ack,
    input  wire logic [31:0] i_mem_rdata,
    // control bits to the rest of the core
    output logic             o_align_check_en,
    output logic             o_prot_s,
    output logic             o_prot_r,
    output logic [31:0]      o_domain_fields
);
    import mmu_pkg::*;
    // ==========================================================
    // helpers
    function automatic logic [31:0] relocate(input logic [31:0] a, input logic [6:0] id);
        relocate = a;
        if (a[31:RELOC_LSB] == 7'h00) begin
            relocate[31:RELOC_LSB] = id;
        end
    endfunction
    function automatic logic [IDX_W-1:0] victim_step(input logic [IDX_W-1:0] v,
                                                    input logic [IDX_W-1:0] b);
        victim_step = (v == VICTIM_MAX) ? b : v + 6'h01;
    endfunction
    // ==========================================================
    // register state
    logic [31:0]      control_reg, control_next;
    logic [31:TB_LSB] table_base_reg, table_base_next;
    logic [31:0]      domain_reg, domain_next;
    logic [31:0]      fault_status_reg, fault_status_next;
    logic [31:0]      fault_address_reg, fault_address_next;
    logic [6:0]       reloc_reg, reloc_next;
    logic [IDX_W-1:0] lk_base_reg [2], lk_base_next [2];
    logic [IDX_W-1:0] lk_vic_reg [2], lk_vic_next [2];
    logic             lk_p_reg [2], lk_p_next [2];
    logic             cp_rvalid_reg, cp_rvalid_next;
    logic [31:0]      cp_rdata_reg, cp_rdata_next;
    // ==========================================================
    // translation buffers
    logic [ENTRIES-1:0] valid_reg [2], valid_next [2];
    logic [ENTRIES-1:0] pres_reg [2], pres_next [2];
    logic [31:L1_IDX_LSB] tag_mem [2][ENTRIES];
    logic [31:0]          desc_mem [2][ENTRIES];
    // ==========================================================
    // walk state
    walk_state_e state_reg, state_next;
    logic        side_reg, side_next;
    logic [31:0] mva_reg, mva_next;
    logic [31:0] desc_reg, desc_next;
    logic        mem_req_reg, mem_req_next;
    logic [29:0] mem_addr_reg, mem_addr_next;
    logic        resp_valid_reg, resp_valid_next;
    logic [31:0] resp_paddr_reg, resp_paddr_next;
    logic        resp_abort_reg, resp_abort_next;
    logic        resp_l2_reg, resp_l2_next;
    logic [31:0] resp_desc_reg, resp_desc_next;
    logic        fill_we;
    logic        hit;
    logic [31:0] hit_desc;
    logic        cp_wr, cp_rd, lk_sel;
    logic [31:0] cp_read_val;
    assign cp_wr  = i_cp_valid & i_cp_write;
    assign cp_rd  = i_cp_valid & ~i_cp_write;
    assign lk_sel = (i_cp_opc2 == OPC2_INSTR);
    // buffer search for the stalled access
    always_comb begin
        hit      = 1'b0;
        hit_desc = 32'h0000_0000;
        for (int i = 0; i < ENTRIES; i++) begin
            if (valid_reg[side_reg][i] &&
                tag_mem[side_reg][i] == mva_reg[31:L1_IDX_LSB]) begin
                hit      = 1'b1;
                hit_desc = desc_mem[side_reg][i];
            end
        end
    end
    // ==========================================================
    // register read mux
    always_comb begin
        cp_read_val = 32'h0000_0000;
        unique case (i_cp_reg)
            REG_CONTROL:      cp_read_val = control_reg;
            REG_TABLE_BASE:   cp_read_val = {table_base_reg, {TB_LSB{1'b0}}};
            REG_DOMAIN:       cp_read_val = domain_reg;
            REG_FAULT_STATUS: cp_read_val = fault_status_reg;
            REG_FAULT_ADDR:   cp_read_val = fault_address_reg;
            REG_LOCKDOWN: begin
                cp_read_val[LK_BASE_MSB:LK_BASE_LSB] = lk_base_reg[lk_sel];
                cp_read_val[LK_VIC_MSB:LK_VIC_LSB]   = lk_vic_reg[lk_sel];
                cp_read_val[LK_P_BIT]                = lk_p_reg[lk_sel];
            end
            REG_RELOC_ID:     cp_read_val[31:RELOC_LSB] = reloc_reg;
            // maintenance register and unmapped numbers read zero
            default:          cp_read_val = 32'h0000_0000;
        endcase
    end
    // ==========================================================
    // register and buffer next values
    always_comb begin
        control_next       = control_reg;
        table_base_next    = table_base_reg;
        domain_next        = domain_reg;
        fault_status_next  = fault_status_reg;
        fault_address_next = fault_address_reg;
        reloc_next         = reloc_reg;
        lk_base_next       = lk_base_reg;
        lk_vic_next        = lk_vic_reg;
        lk_p_next          = lk_p_reg;
        valid_next         = valid_reg;
        pres_next          = pres_reg;
        cp_rvalid_next     = cp_rd;
        cp_rdata_next      = cp_rd ? cp_read_val : 32'h0000_0000;

        // fill lands before software writes, so a victim rewrite wins
        if (fill_we) begin
            valid_next[side_reg][lk_vic_reg[side_reg]] = 1'b1;
            pres_next[side_reg][lk_vic_reg[side_reg]]  = lk_p_reg[side_reg];
            lk_vic_next[side_reg] = victim_step(lk_vic_reg[side_reg], lk_base_reg[side_reg]);
        end

        // hardware fault capture
        if (state_reg == ST_FETCH && i_mem_ack &&
            desc_type_e'(i_mem_rdata[1:0]) == DESC_INVALID) begin
            fault_status_next[FS_DOM_MSB:FS_DOM_LSB] = i_mem_rdata[DESC_DOM_MSB:DESC_DOM_LSB];
            fault_status_next[3:0] = FAULT_SECTION_XLAT;
            if (side_reg == 1'(SIDE_DATA)) begin
                fault_address_next = mva_reg;
            end
        end

        if (cp_wr) begin
            unique case (i_cp_reg)
                REG_CONTROL: begin
                    control_next = 32'h0000_0000;
                    control_next[CTRL_M_BIT] = i_cp_wdata[CTRL_M_BIT];
                    control_next[CTRL_A_BIT] = i_cp_wdata[CTRL_A_BIT];
                    control_next[CTRL_S_BIT] = i_cp_wdata[CTRL_S_BIT];
                    control_next[CTRL_R_BIT] = i_cp_wdata[CTRL_R_BIT];
                end
                REG_TABLE_BASE:   table_base_next = i_cp_wdata[31:TB_LSB];
                REG_DOMAIN:       domain_next = i_cp_wdata;
                REG_FAULT_STATUS: fault_status_next = i_cp_wdata;
                REG_FAULT_ADDR:   fault_address_next = i_cp_wdata;
                REG_RELOC_ID:     reloc_next = i_cp_wdata[31:RELOC_LSB];
                REG_LOCKDOWN: begin
                    lk_base_next[lk_sel] = i_cp_wdata[LK_BASE_MSB:LK_BASE_LSB];
                    lk_vic_next[lk_sel]  = i_cp_wdata[LK_VIC_MSB:LK_VIC_LSB];
                    lk_p_next[lk_sel]    = i_cp_wdata[LK_P_BIT];
                end
                REG_BUF_OPS: begin
                    for (int s = 0; s < 2; s++) begin
                        if (i_cp_crm == CRM_BOTH ||
                            (s == SIDE_DATA && i_cp_crm == CRM_DATA) ||
                            (s == SIDE_INSTR && i_cp_crm == CRM_INSTR)) begin
                            for (int i = 0; i < ENTRIES; i++) begin
                                if (i_cp_opc2 == OPS_INV_ALL && !pres_next[s][i]) begin
                                    valid_next[s][i] = 1'b0;
                                end
                                if (i_cp_opc2 == OPS_INV_ENTRY &&
                                    tag_mem[s][i] == i_cp_wdata[31:L1_IDX_LSB]) begin
                                    valid_next[s][i] = 1'b0;
                                end
                            end
                        end
                    end
                end
                default: ;
            endcase
        end
    end
    // ==========================================================
    // walk sequencer
    always_comb begin
        state_next      = state_reg;
        side_next       = side_reg;
        mva_next        = mva_reg;
        desc_next       = desc_reg;
        mem_req_next    = mem_req_reg;
        mem_addr_next   = mem_addr_reg;
        resp_valid_next = 1'b0;
        resp_paddr_next = resp_paddr_reg;
        resp_abort_next = resp_abort_reg;
        resp_l2_next    = resp_l2_reg;
        resp_desc_next  = resp_desc_reg;
        fill_we         = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (i_req_valid) begin
                    side_next  = i_req_instr;
                    mva_next   = relocate(i_req_addr, reloc_reg);
                    state_next = ST_LOOKUP;
                end
            end
            ST_LOOKUP: begin
                if (!control_reg[CTRL_M_BIT]) begin
                    // translation off: flat mapping
                    resp_paddr_next = mva_reg;
                    resp_abort_next = 1'b0;
                    resp_l2_next    = 1'b0;
                    resp_desc_next  = 32'h0000_0000;
                    state_next      = ST_RESP;
                end else if (hit) begin
                    resp_desc_next  = hit_desc;
                    resp_abort_next = 1'b0;
                    resp_l2_next    = (desc_type_e'(hit_desc[1:0]) != DESC_SECTION);
                    resp_paddr_next = {hit_desc[31:L1_IDX_LSB], mva_reg[L1_IDX_LSB-1:0]};
                    state_next      = ST_RESP;
                end else begin
                    mem_req_next  = 1'b1;
                    mem_addr_next = {table_base_reg, mva_reg[31:L1_IDX_LSB]};
                    state_next    = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (i_mem_ack) begin
                    mem_req_next = 1'b0;
                    desc_next    = i_mem_rdata;
                    if (desc_type_e'(i_mem_rdata[1:0]) == DESC_INVALID) begin
                        resp_abort_next = 1'b1;
                        resp_l2_next    = 1'b0;
                        resp_paddr_next = mva_reg;
                        resp_desc_next  = i_mem_rdata;
                        state_next      = ST_RESP;
                    end else begin
                        state_next = ST_FILL;
                    end
                end
            end
            ST_FILL: begin
                fill_we    = 1'b1;
                state_next = ST_LOOKUP;
            end
            ST_RESP: begin
                resp_valid_next = 1'b1;
                state_next      = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end
    // ==========================================================
    // registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            control_reg       <= CONTROL_RST;
            table_base_reg    <= '0;
            domain_reg        <= 32'h0000_0000;
            fault_status_reg  <= 32'h0000_0000;
            fault_address_reg <= 32'h0000_0000;
            reloc_reg         <= RELOC_RST;
            lk_base_reg    <= '{default: '0};
            lk_vic_reg     <= '{default: '0};
            lk_p_reg       <= '{default: 1'b0};
            valid_reg      <= '{default: '0};
            pres_reg       <= '{default: '0};
            cp_rvalid_reg  <= 1'b0;
            cp_rdata_reg   <= 32'h0000_0000;
            state_reg      <= ST_IDLE;
            side_reg       <= 1'b0;
            mva_reg        <= 32'h0000_0000;
            desc_reg       <= 32'h0000_0000;
            mem_req_reg    <= 1'b0;
            mem_addr_reg   <= 30'h0000_0000;
            resp_valid_reg <= 1'b0;
            resp_paddr_reg <= 32'h0000_0000;
            resp_abort_reg <= 1'b0;
            resp_l2_reg    <= 1'b0;
            resp_desc_reg  <= 32'h0000_0000;
        end else begin
            control_reg       <= control_next;
            table_base_reg    <= table_base_next;
            domain_reg        <= domain_next;
            fault_status_reg  <= fault_status_next;
            fault_address_reg <= fault_address_next;
            reloc_reg         <= reloc_next;
            lk_base_reg       <= lk_base_next;
            lk_vic_reg        <= lk_vic_next;
            lk_p_reg          <= lk_p_next;
            valid_reg         <= valid_next;
            pres_reg          <= pres_next;
            cp_rvalid_reg     <= cp_rvalid_next;
            cp_rdata_reg      <= cp_rdata_next;
            state_reg         <= state_next;
            side_reg          <= side_next;
            mva_reg           <= mva_next;
            desc_reg          <= desc_next;
            mem_req_reg       <= mem_req_next;
            mem_addr_reg      <= mem_addr_next;
            resp_valid_reg    <= resp_valid_next;
            resp_paddr_reg    <= resp_paddr_next;
            resp_abort_reg    <= resp_abort_next;
            resp_l2_reg       <= resp_l2_next;
            resp_desc_reg     <= resp_desc_next;
        end
    end
    // entry storage needs no reset; the valid bits guard it
    always_ff @(posedge i_clk_sys) begin
        if (fill_we) begin
            tag_mem[side_reg][lk_vic_reg[side_reg]]  <= mva_reg[31:L1_IDX_LSB];
            desc_mem[side_reg][lk_vic_reg[side_reg]] <= desc_reg;
        end
    end
    // ==========================================================
    // outputs
    assign o_cp_rvalid      = cp_rvalid_reg;
    assign o_cp_rdata       = cp_rdata_reg;
    assign o_req_ready      = (state_reg == ST_IDLE);
    assign o_resp_valid     = resp_valid_reg;
    assign o_resp_paddr     = resp_paddr_reg;
    assign o_resp_abort     = resp_abort_reg;
    assign o_resp_level2    = resp_l2_reg;
    assign o_resp_desc      = resp_desc_reg;
    assign o_mem_req        = mem_req_reg;
    assign o_mem_addr       = mem_addr_reg;
    assign o_align_check_en = control_reg[CTRL_A_BIT];
    assign o_prot_s         = control_reg[CTRL_S_BIT];
    assign o_prot_r         = control_reg[CTRL_R_BIT];
    assign o_domain_fields  = domain_reg;
endmodule // mmu_level_one

/* File: tb/mmu_level_one_monitor.sv */
// port assertions for the level one translation block
`timescale 1ns/1ps
// ==========================================================
// checker
module mmu_level_one_monitor
    import mmu_pkg::*;
(
    input wire logic i_clk_sys, i_rstn, i_cp_valid, i_cp_write, o_cp_rvalid, i_req_valid,
    input wire logic o_req_ready, o_resp_valid, o_resp_abort, o_resp_level2, o_mem_req,
    input wire logic i_mem_ack, o_align_check_en, o_prot_s, o_prot_r,
    input wire logic [3:0] i_cp_reg,
    input wire logic [29:0] o_mem_addr,
    input wire logic [31:0] i_cp_wdata, o_cp_rdata, o_resp_desc, o_domain_fields
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    a_read_answer: assert property (i_cp_valid && !i_cp_write |=> o_cp_rvalid)
        else $error("read transfer got no answer");
    a_no_stray_answer: assert property (!(i_cp_valid && !i_cp_write) |=> !o_cp_rvalid)
        else $error("answer without read");
    a_base_low_zero: assert property (o_cp_rvalid && $past(i_cp_reg) == REG_TABLE_BASE
        |-> o_cp_rdata[13:0] == 14'h0000)
        else $error("table base low bits not zero");
    a_ops_unread: assert property (o_cp_rvalid && $past(i_cp_reg) == REG_BUF_OPS
        |-> o_cp_rdata == 32'h0000_0000)
        else $error("maintenance register readable");
    a_domain_write: assert property (i_cp_valid && i_cp_write && i_cp_reg == REG_DOMAIN
        |=> o_domain_fields == $past(i_cp_wdata))
        else $error("domain fields not updated");
    a_control_pins: assert property (i_cp_valid && i_cp_write && i_cp_reg == REG_CONTROL
        |=> {o_align_check_en, o_prot_s, o_prot_r} == $past({i_cp_wdata[1], i_cp_wdata[9:8]}))
        else $error("control bits not updated");
    a_fetch_hold: assert property (o_mem_req && !i_mem_ack
        |=> o_mem_req && $stable(o_mem_addr))
        else $error("fetch request dropped early");
    a_walk_answer: assert property (i_req_valid && o_req_ready |=> ##[0:60] o_resp_valid)
        else $error("access got no answer");
    a_abort_invalid: assert property (o_resp_valid && o_resp_abort
        |-> o_resp_desc[1:0] == 2'b00 && !o_resp_level2)
        else $error("abort without invalid descriptor");
    a_level_two: assert property (o_resp_valid && o_resp_desc[0] |-> o_resp_level2)
        else $error("page table not flagged");
endmodule // mmu_level_one_monitor

bind mmu_level_one mmu_level_one_monitor i_mmu_level_one_monitor (.*);

/* File: tb/mmu_mem_model.sv */
// physical memory answering level one descriptor fetches
`timescale 1ns/1ps
module mmu_mem_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic        i_req,
    input  wire logic [29:0] i_addr,
    input  wire logic [31:0] i_desc,
    input  wire logic [3:0]  i_wait,
    output logic             o_ack,
    output logic [31:0]      o_rdata,
    output logic [29:0]      o_last_addr,
    output logic [7:0]       o_fetches
);
    logic [3:0] cnt_reg;
    // data is inverted every cycle without an answer so a stale word repeats the last answer only on every second cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            cnt_reg   <= 4'h0;
            o_ack     <= 1'b0;
            o_rdata   <= 32'h5A5A_5A5A;
            o_fetches <= 8'h00;
        end else if (i_req && !o_ack && cnt_reg == i_wait) begin
            o_ack       <= 1'b1;
            o_rdata     <= i_desc;
            o_last_addr <= i_addr;
            o_fetches   <= o_fetches + 8'h01;
            cnt_reg     <= 4'h0;
        end else begin
            o_ack   <= 1'b0;
            o_rdata <= ~o_rdata;
            cnt_reg <= (i_req && !o_ack) ? cnt_reg + 4'h1 : 4'h0;
        end
    end
endmodule // mmu_mem_model

/* File: tb/mmu_level_one_bench.sv */
// self-checking bench for the level one translation block
`timescale 1ns/1ps
module mmu_level_one_bench;
    import mmu_pkg::*;
    logic clk, rstn, cpv, cpw_, rv, req, ins, rdy, resp, ab, l2, mreq, ack, al, ps, pr;
    logic [3:0] reg_, crm, wt;
    logic [2:0] opc;
    logic [31:0] wd, rd, addr, pa, dsc, rdesc, mrd, dom;
    logic [29:0] maddr, last;
    logic [7:0] fet;
    int num_errors = 0, checked = 0, cyc = 0;
    mmu_level_one i_mmu_level_one (.i_clk_sys(clk), .i_rstn(rstn), .i_cp_valid(cpv),
        .i_cp_write(cpw_), .i_cp_reg(reg_), .i_cp_crm(crm), .i_cp_opc2(opc), .i_cp_wdata(wd),
        .o_cp_rvalid(rv), .o_cp_rdata(rd), .i_req_valid(req), .i_req_instr(ins),
        .i_req_addr(addr), .o_req_ready(rdy), .o_resp_valid(resp), .o_resp_paddr(pa),
        .o_resp_abort(ab), .o_resp_level2(l2), .o_resp_desc(rdesc), .o_mem_req(mreq),
        .o_mem_addr(maddr), .i_mem_ack(ack), .i_mem_rdata(mrd), .o_align_check_en(al),
        .o_prot_s(ps), .o_prot_r(pr), .o_domain_fields(dom));
    mmu_mem_model i_mmu_mem_model (.i_clk_sys(clk), .i_rstn(rstn), .i_req(mreq),
        .i_addr(maddr), .i_desc(dsc), .i_wait(wt), .o_ack(ack), .o_rdata(mrd),
        .o_last_addr(last), .o_fetches(fet));
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    // ==========================================================
    // shared tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cw(input logic [3:0] r, input logic [3:0] m, input logic [2:0] o,
                      input logic [31:0] d);
        @(negedge clk); cpv = 1; cpw_ = 1; reg_ = r; crm = m; opc = o; wd = d;
        @(negedge clk); cpv = 0;
    endtask
    task automatic cr(input string n, input logic [3:0] r, input logic [2:0] o,
                      input logic [31:0] e, input logic [31:0] k = 32'hFFFF_FFFF);
        @(negedge clk); cpv = 1; cpw_ = 0; reg_ = r; opc = o;
        @(negedge clk); cpv = 0;
        chk(n, e & k, rd & k);
    endtask
    task automatic acc(input logic i, input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] ep, input logic [1:0] ef, input logic [7:0] nf);
        int n;
        dsc = d;
        @(negedge clk); req = 1; ins = i; addr = a;
        @(negedge clk); req = 0;
        n = 0;
        while (resp !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        if (!ef[0]) chk("paddr", ep, pa);
        chk("flags", {30'h0, ef}, {30'h0, ab, l2});
        chk("fetches", {24'h0, nf}, {24'h0, fet});
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs;
        cw(REG_CONTROL, 0, 0, 32'hFFFF_FFFE);
        cr("ctrl", REG_CONTROL, 0, 32'h0000_0302);
        chk("pins", 32'h7, {29'h0, al, ps, pr});
        cw(REG_CONTROL, 0, 0, 32'h0);
        cw(REG_TABLE_BASE, 0, 0, 32'hFFFF_FFFF);
        cr("base", REG_TABLE_BASE, 0, 32'hFFFF_C000);
        cw(REG_DOMAIN, 0, 0, 32'hC3A5_1E96);
        cr("domain", REG_DOMAIN, 0, 32'hC3A5_1E96);
        chk("dompins", 32'hC3A5_1E96, dom);
        cw(REG_FAULT_ADDR, 0, 0, 32'hDEAD_BEEF);
        cr("faddr", REG_FAULT_ADDR, 0, 32'hDEAD_BEEF);
        cw(REG_FAULT_STATUS, 0, 0, 32'h0000_00A7);
        cr("fstat", REG_FAULT_STATUS, 0, 32'hA7, 32'hFF);
        cr("ops", REG_BUF_OPS, 0, 32'h0);
        cw(REG_LOCKDOWN, 0, OPC2_DATA, 32'h0C30_0001);
        cw(REG_LOCKDOWN, 0, OPC2_INSTR, 32'h1450_0000);
        cr("lockd", REG_LOCKDOWN, OPC2_DATA, 32'h0C30_0001, 32'hFFF0_0001);
        cr("locki", REG_LOCKDOWN, OPC2_INSTR, 32'h1450_0000, 32'hFFF0_0001);
    endtask
    task automatic t_walk;
        acc(0, 32'h8765_4321, 32'hFFFF_FFFF, 32'h8765_4321, 2'b00, 0);
        cw(REG_TABLE_BASE, 0, 0, 32'h0012_7FFF);
        cw(REG_CONTROL, 0, 0, 32'h1);
        acc(0, 32'h1234_5678, 32'hABC0_0C12, 32'hABC4_5678, 2'b00, 1);
        chk("l1addr", {2'b0, 18'h00049, 12'h123}, {2'b0, last});
        acc(0, 32'h1234_5678, 32'h0, 32'hABC4_5678, 2'b00, 1);
        acc(1, 32'h1234_5678, 32'hABC0_0C12, 32'hABC4_5678, 2'b00, 2);
        cw(REG_RELOC_ID, 0, 0, 32'h0600_0000);
        acc(1, 32'h0010_0000, 32'h3000_0012, 32'h3000_0000, 2'b00, 3);
        chk("reloc", {20'h0, 12'h061}, {20'h0, last[11:0]});
        acc(1, 32'h0210_0000, 32'h3000_0012, 32'h3000_0000, 2'b00, 4);
        chk("noreloc", {20'h0, 12'h021}, {20'h0, last[11:0]});
    endtask
    task automatic t_fault;
        acc(0, 32'h4567_89AB, 32'h0000_01E0, 32'h4567_89AB, 2'b10, 5);
        cr("fstat", REG_FAULT_STATUS, 0, 32'hF5, 32'hFF);
        cr("faddr", REG_FAULT_ADDR, 0, 32'h4567_89AB);
        acc(1, 32'h6000_0000, 32'h0000_0040, 32'h6000_0000, 2'b10, 6);
        cr("fstat", REG_FAULT_STATUS, 0, 32'h25, 32'hFF);
        cr("faddr", REG_FAULT_ADDR, 0, 32'h4567_89AB);
        acc(0, 32'h5000_0000, 32'h7777_7C01, 32'h0, 2'b01, 7);
        acc(0, 32'h5100_0000, 32'h7777_7C03, 32'h0, 2'b01, 8);
    endtask
    task automatic t_maint;
        cw(REG_LOCKDOWN, 0, OPC2_DATA, 32'h0000_0001);
        acc(0, 32'h7000_0000, 32'h7000_0002, 32'h7000_0000, 2'b00, 9);
        cw(REG_LOCKDOWN, 0, OPC2_DATA, 32'h0410_0000);
        cw(REG_BUF_OPS, CRM_DATA, OPS_INV_ENTRY, 32'h1234_5678);
        acc(0, 32'h1234_5678, 32'hABC0_0C12, 32'hABC4_5678, 2'b00, 10);
        cw(REG_BUF_OPS, CRM_BOTH, OPS_INV_ALL, 32'h0);
        acc(0, 32'h7000_0000, 32'h0, 32'h7000_0000, 2'b00, 10);
        acc(0, 32'h1234_5678, 32'hABC0_0C12, 32'hABC4_5678, 2'b00, 11);
    endtask
    task automatic conclude;
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================================
    // main sequence and hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        rstn = 0; cpv = 0; cpw_ = 0; reg_ = 0; crm = 0; opc = 0; wd = 0;
        req = 0; ins = 0; addr = 0; dsc = 0; wt = 4'h2;
        repeat (10) @(negedge clk);
        rstn = 1;
        chk("ready", 32'h1, {31'h0, rdy});
        t_regs();
        t_walk();
        t_fault();
        t_maint();
        conclude();
    end
endmodule // mmu_level_one_bench
